//--- spg_pkg.sv
package spg_pkg;
  // Generation-mode codes
  localparam logic [2:0] GM_BUFFER = 3'h0;
  localparam logic [2:0] GM_SYNC   = 3'h1;
  localparam logic [2:0] GM_EXT    = 3'h2;
  localparam logic [2:0] GM_INT    = 3'h3;
  localparam logic [2:0] GM_CONT   = 3'h4;
  localparam logic [2:0] GM_TERM   = 3'h7;
  // Trigger-option codes
  localparam logic [1:0] TO_00 = 2'h0;
  localparam logic [1:0] TO_01 = 2'h1;
  localparam logic [1:0] TO_10 = 2'h2;
  localparam logic [1:0] TO_11 = 2'h3;
  // Sizes
  localparam int NUM_CH    = 8;
  localparam int CNT_W     = 8;
  localparam int DLY_W     = 6;
  localparam int DLY_DEPTH = 64;
  // Lowest channel divider allowed for retimed pass-through
  localparam int PASS_MIN_DIV = 8;
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
  localparam logic [2:0]       TAP_RST  = 3'h0;
  // Pulse engine states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BURST = 2'b01,
    ST_GAP   = 2'b10
  } spg_state_t;
endpackage

//--- spg_rx_model.sv
`timescale 1ns/1ps
// Far-side converter view of one sysref output pair
module spg_rx_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_clr,
  // Differential legs and output state
  input  wire logic        i_q,
  input  wire logic        i_qn,
  input  wire logic        i_pwr,
  input  wire logic        i_xpt,
  // Observations
  output logic      [15:0] o_pulses,
  output logic      [15:0] o_last_high,
  output logic      [15:0] o_low_max,
  output logic             o_leg_err
);
  logic        q_d;
  logic [15:0] run;

  // Pulse counter and level run lengths, in clock cycles
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q_d         <= 1'b0;
      run         <= 16'h0000;
      o_pulses    <= 16'h0000;
      o_last_high <= 16'h0000;
      o_low_max   <= 16'h0000;
      o_leg_err   <= 1'b0;
    end else if (i_clr) begin
      q_d         <= i_q;
      run         <= 16'h0001;
      o_pulses    <= 16'h0000;
      o_last_high <= 16'h0000;
      o_low_max   <= 16'h0000;
      o_leg_err   <= 1'b0;
    end else begin
      q_d <= i_q;
      run <= (i_q !== q_d) ? 16'h0001 : run + 16'h0001;
      if (i_q && !q_d) begin
        o_pulses <= o_pulses + 16'h0001;
        // Gaps only count between pulses, idle time before the first is ignored
        if (o_pulses != 16'h0000 && run > o_low_max) o_low_max <= run;
      end
      if (!i_q && q_d) o_last_high <= run;
      // A powered, switching pair must never show equal legs
      if (i_pwr && !i_xpt && i_q === i_qn) o_leg_err <= 1'b1;
    end
  end
endmodule

//--- spg_sync2.sv
`timescale 1ns/1ps
module spg_sync2 (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_ce,
  // Asynchronous level in, synchronised level out
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta;

  // Two flops; the first is read only by the second
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end else if (i_ce) begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

//--- spg_sysref_gen.sv
`timescale 1ns/1ps
// Overview of operation
// - Retimed pass-through follows sync on next edge
// - Pulsed and continuous modes have even duty
// - Counted burst emits programmed count then stops
// - Repeat mode alternates burst and wait gap
// - Terminate stops only after whole pulse
// - Event start powers up sysref outputs
// - Pulsed event end returns outputs off
// - Bias type zero rests static low
// - Bias type one rests at crosspoint
// - All outputs aligned to common edge
// - Same settings give same phases always
// - Mode 000 buffers, 001 retimes sync
// - External trigger option selects edge behaviour
// - Internal trigger: single or repeating bursts
// - Continuous start selection, stop by terminate
module spg_sysref_gen (
  // Clock, reset, enable
  input  wire logic                                        i_clk,
  input  wire logic                                        i_arst_n,
  input  wire logic                                        i_ce,
  // External sync pin
  input  wire logic                                        i_ext_sync_input,
  // Configuration
  input  wire logic [2:0]                                  i_sysref_gen_mode,
  input  wire logic [1:0]                                  i_sysref_trigger_option,
  input  wire logic [spg_pkg::CNT_W-1:0]                   i_sysref_pulse_count,
  input  wire logic [spg_pkg::CNT_W-1:0]                   i_sysref_wait_count,
  input  wire logic [spg_pkg::CNT_W-1:0]                   i_sysref_half_period,
  input  wire logic                                        i_start_arm,
  input  wire logic                                        i_bias_type,
  input  wire logic                                        i_idle_bias_select,
  input  wire logic [spg_pkg::NUM_CH-1:0]                  i_chan_is_sysref,
  input  wire logic [spg_pkg::NUM_CH*spg_pkg::DLY_W-1:0]   i_chan_delay,
  // Channel outputs
  output logic      [spg_pkg::NUM_CH-1:0]                  o_chan_output,
  output logic      [spg_pkg::NUM_CH-1:0]                  o_channel_output_comp,
  output logic      [spg_pkg::NUM_CH-1:0]                  o_chan_power,
  output logic      [spg_pkg::NUM_CH-1:0]                  o_crosspoint_level,
  // Status
  output logic                                             o_busy
);
  localparam int W = spg_pkg::CNT_W;

  spg_pkg::spg_state_t st, next_st;
  logic [W-1:0] pcnt, next_pcnt, wcnt, next_wcnt, hcnt, next_hcnt, pcfg, next_pcfg;
  logic         ph, next_ph, cont_q, next_cont, rpt_q, next_rpt, stop_req, next_stop;
  logic         sync_s, sync_d, arm_d, armed, pass_lvl, clk_tog;
  logic [2:0]   dline [spg_pkg::DLY_DEPTH];

  // Sync pin crosses into the divider clock domain
  spg_sync2 u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_ce     (i_ce),
    .i_async  (i_ext_sync_input),
    .o_sync   (sync_s)
  );

  // Mode and edge decode
  wire [2:0] mode      = i_sysref_gen_mode;
  wire [1:0] opt       = i_sysref_trigger_option;
  wire       rise      = sync_s & ~sync_d;
  wire       fall      = ~sync_s & sync_d;
  wire       arm_set   = i_start_arm & ~arm_d;
  wire       m_ext     = (mode == spg_pkg::GM_EXT);
  wire       m_int     = (mode == spg_pkg::GM_INT);
  wire       m_cont    = (mode == spg_pkg::GM_CONT);
  wire       m_term    = (mode == spg_pkg::GM_TERM);
  wire       m_pass    = (mode == spg_pkg::GM_BUFFER) | (mode == spg_pkg::GM_SYNC);
  wire       ext_edge0 = (opt == spg_pkg::TO_00) ? rise : fall;
  wire       ext_edge1 = (opt == spg_pkg::TO_10) ? rise : fall;
  wire       ext_stop1 = (opt == spg_pkg::TO_10) ? fall : rise;

  // Trigger sources per mode; external triggers need the arm bit first
  wire trig_cnt  = (m_ext & armed & ~opt[1] & ext_edge0)
                 | (m_int & (opt == spg_pkg::TO_00) & arm_set);
  wire trig_rpt  = m_int & (opt == spg_pkg::TO_01) & arm_set;
  wire trig_cont = (m_ext & armed & opt[1] & ext_edge1)
                 | (m_cont & ((~opt[0] & arm_set)
                 | ((opt == spg_pkg::TO_01) & rise)
                 | ((opt == spg_pkg::TO_11) & fall)));
  wire ext_stop  = m_ext & opt[1] & ext_stop1;
  wire start_go  = (st == spg_pkg::ST_IDLE) & (trig_cnt | trig_rpt | trig_cont);

  // Programmed values, zero read as one
  wire [W-1:0] half_v = (i_sysref_half_period == spg_pkg::CNT_RST) ? spg_pkg::CNT_ONE
                      : i_sysref_half_period;
  wire [W-1:0] hmax   = half_v - spg_pkg::CNT_ONE;
  wire [W-1:0] pc_v   = (i_sysref_pulse_count == spg_pkg::CNT_RST) ? spg_pkg::CNT_ONE
                      : i_sysref_pulse_count;
  wire [W-1:0] wc_v   = (i_sysref_wait_count == spg_pkg::CNT_RST) ? spg_pkg::CNT_ONE
                      : i_sysref_wait_count;
  wire busy      = (st != spg_pkg::ST_IDLE);
  wire half_end  = busy & (hcnt == spg_pkg::CNT_RST);
  wire pulse_end = half_end & ~ph;
  wire pulse_hi  = (st == spg_pkg::ST_BURST) & ph;

  // Pulse engine next state
  always_comb begin
    next_st   = st;
    next_pcnt = pcnt;
    next_wcnt = wcnt;
    next_hcnt = hcnt;
    next_pcfg = pcfg;
    next_ph   = ph;
    next_cont = cont_q;
    next_rpt  = rpt_q;
    next_stop = stop_req | (busy & (m_term | ext_stop));
    case (st)
      spg_pkg::ST_IDLE: begin
        next_ph   = 1'b0;
        next_stop = 1'b0;
        if (start_go) begin
          next_st   = spg_pkg::ST_BURST;
          next_ph   = 1'b1;
          next_hcnt = hmax;
          next_pcnt = pc_v;
          next_pcfg = pc_v;
          next_wcnt = wc_v;
          next_cont = trig_cont;
          next_rpt  = trig_rpt;
        end
      end
      spg_pkg::ST_BURST, spg_pkg::ST_GAP: begin
        if ((st == spg_pkg::ST_GAP) && next_stop) begin
          // Nothing on the wire during a gap, so stop at once
          next_st = spg_pkg::ST_IDLE;
        end else if (!half_end) begin
          next_hcnt = hcnt - spg_pkg::CNT_ONE;
        end else begin
          next_hcnt = hmax;
          next_ph   = ~ph;
          if (!ph) begin
            if (next_stop) begin
              next_st = spg_pkg::ST_IDLE;
            end else if (st == spg_pkg::ST_BURST) begin
              if (cont_q) begin
                next_st = spg_pkg::ST_BURST;
              end else if (pcnt == spg_pkg::CNT_ONE) begin
                next_st   = rpt_q ? spg_pkg::ST_GAP : spg_pkg::ST_IDLE;
                next_wcnt = wc_v;
              end else begin
                next_pcnt = pcnt - spg_pkg::CNT_ONE;
              end
            end else if (wcnt == spg_pkg::CNT_ONE) begin
              next_st   = spg_pkg::ST_BURST;
              next_pcnt = pc_v;
              next_pcfg = pc_v;
            end else begin
              next_wcnt = wcnt - spg_pkg::CNT_ONE;
            end
          end
        end
      end
      default: begin
        next_st = spg_pkg::ST_IDLE;
      end
    endcase
  end

  // Pulse engine registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st       <= spg_pkg::ST_IDLE;
      pcnt     <= spg_pkg::CNT_RST;
      wcnt     <= spg_pkg::CNT_RST;
      hcnt     <= spg_pkg::CNT_RST;
      pcfg     <= spg_pkg::CNT_RST;
      ph       <= 1'b0;
      cont_q   <= 1'b0;
      rpt_q    <= 1'b0;
      stop_req <= 1'b0;
    end else if (i_ce) begin
      st       <= next_st;
      pcnt     <= next_pcnt;
      wcnt     <= next_wcnt;
      hcnt     <= next_hcnt;
      pcfg     <= next_pcfg;
      ph       <= next_ph;
      cont_q   <= next_cont;
      rpt_q    <= next_rpt;
      stop_req <= next_stop;
    end
  end

  // Edge history, arm flag, retimed pass level, clock-channel toggle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_d   <= 1'b0;
      arm_d    <= 1'b0;
      armed    <= 1'b0;
      pass_lvl <= 1'b0;
      clk_tog  <= 1'b0;
    end else if (i_ce) begin
      sync_d   <= sync_s;
      arm_d    <= i_start_arm;
      armed    <= m_ext & (armed | arm_set);
      pass_lvl <= sync_s;
      clk_tog  <= ~clk_tog;
    end
  end

  // Core sysref level; idle-bias high on bias type 0 keeps it low outside modes 000 and 001
  wire quiet    = ~i_bias_type & i_idle_bias_select;
  wire pass_q   = (mode == spg_pkg::GM_SYNC) ? pass_lvl : sync_s;
  wire core_q   = m_pass ? pass_q : (pulse_hi & ~quiet);
  wire core_pwr = m_pass | busy;

  // One shared delay line keeps every channel on the same launch edge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dline[0] <= spg_pkg::TAP_RST;
    end else if (i_ce) begin
      dline[0] <= {clk_tog, core_pwr, core_q};
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < spg_pkg::DLY_DEPTH; gi++) begin : g_dly
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          dline[gi] <= spg_pkg::TAP_RST;
        end else if (i_ce) begin
          dline[gi] <= dline[gi-1];
        end
      end
    end
  endgenerate

  // Per channel tap and output stage
  generate
    for (gi = 0; gi < spg_pkg::NUM_CH; gi++) begin : g_ch
      wire [spg_pkg::DLY_W-1:0] dsel = i_chan_delay[gi*spg_pkg::DLY_W +: spg_pkg::DLY_W];
      wire [2:0] tap  = dline[dsel];
      wire       srf  = i_chan_is_sysref[gi];
      wire       xpt  = srf & ~tap[1] & i_bias_type;
      wire       q    = srf ? (tap[1] & tap[0]) : tap[2];
      wire       qn   = srf ? (tap[1] ? ~tap[0] : ~i_bias_type) : ~tap[2];
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          o_chan_output[gi]         <= 1'b0;
          o_channel_output_comp[gi] <= 1'b1;
          o_chan_power[gi]          <= 1'b0;
          o_crosspoint_level[gi]    <= 1'b0;
        end else if (i_ce) begin
          o_chan_output[gi]         <= q;
          o_channel_output_comp[gi] <= qn;
          o_chan_power[gi]          <= ~srf | tap[1];
          o_crosspoint_level[gi]    <= xpt;
        end
      end
      // Equal delays give equal sysref outputs
      AST_ALIGN: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (srf && i_chan_is_sysref[0] && dsel == i_chan_delay[spg_pkg::DLY_W-1:0])
        |-> o_chan_output[gi] == o_chan_output[0])
        else $error("sysref channels with equal delay disagree");
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_busy <= 1'b0;
    end else if (i_ce) begin
      o_busy <= busy;
    end
  end

  // Assertion helpers: high-run length and pulses in this burst
  logic [W-1:0] hi_len, npulse;
  logic         hi_d;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hi_len <= spg_pkg::CNT_RST;
      npulse <= spg_pkg::CNT_RST;
      hi_d   <= 1'b0;
    end else if (i_ce) begin
      hi_d   <= pulse_hi;
      hi_len <= pulse_hi ? hi_len + spg_pkg::CNT_ONE : spg_pkg::CNT_RST;
      if (start_go || (st == spg_pkg::ST_GAP)) begin
        npulse <= spg_pkg::CNT_RST;
      end else if (pulse_hi && !hi_d) begin
        npulse <= npulse + spg_pkg::CNT_ONE;
      end
    end
  end

  default clocking cb @(posedge i_clk iff i_ce); endclocking
  default disable iff (!i_arst_n);

  AST_PASS_SYNC: assert property (
    (mode == spg_pkg::GM_SYNC && $rose(sync_s)) |=> ##1 dline[0][0])
    else $error("retimed pass-through missed a sync rise");
  AST_DUTY: assert property (
    (st == spg_pkg::ST_BURST && $fell(pulse_hi)) |-> hi_len == half_v)
    else $error("sysref high half has wrong length");
  AST_COUNT: assert property (
    (st == spg_pkg::ST_BURST && next_st == spg_pkg::ST_IDLE && !cont_q && !stop_req
     && !next_stop) |-> npulse == pcfg)
    else $error("burst pulse count mismatch");
  AST_GAP_QUIET: assert property (
    (st == spg_pkg::ST_GAP) |=> !pulse_hi || $past(wcnt == spg_pkg::CNT_ONE))
    else $error("pulse seen inside wait gap");
  AST_NO_RUNT: assert property (
    (st == spg_pkg::ST_BURST && next_st == spg_pkg::ST_IDLE) |-> pulse_end)
    else $error("burst ended mid-pulse");
  AST_POWER_UP: assert property (
    start_go |=> core_pwr ##1 dline[0][1])
    else $error("outputs not powered at event start");
  AST_QUIET_LOW: assert property (
    (!m_pass && quiet) |=> !dline[0][0])
    else $error("idle-biased output toggled");
  AST_RELEASE: assert property (
    (!m_pass && busy ##1 !busy) |-> ##1 !dline[0][1] && !dline[0][0])
    else $error("outputs not released after event");
  AST_REPEAT: assert property (
    (m_int && opt == spg_pkg::TO_01 && start_go) |=> rpt_q && st == spg_pkg::ST_BURST)
    else $error("auto-repeat burst did not start");

  COV_COUNTED: cover property (st == spg_pkg::ST_BURST ##1 st == spg_pkg::ST_IDLE);
  COV_GAP:     cover property (st == spg_pkg::ST_GAP ##1 st == spg_pkg::ST_BURST);
  COV_TERM:    cover property (cont_q && m_term ##[1:600] st == spg_pkg::ST_IDLE);
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        i_clk, i_arst_n, i_ce, i_ext_sync_input, i_start_arm, i_bias_type;
  logic        i_idle_bias_select, clr;
  logic [2:0]  i_sysref_gen_mode;
  logic [1:0]  i_sysref_trigger_option;
  logic [7:0]  i_sysref_pulse_count, i_sysref_wait_count, i_sysref_half_period;
  logic [7:0]  i_chan_is_sysref, o_chan_output, o_channel_output_comp;
  logic [7:0]  o_chan_power, o_crosspoint_level;
  logic [47:0] i_chan_delay;
  logic        o_busy, leg_err;
  logic [15:0] pulses, last_high, low_max;
  int          failures, compares, k;

  spg_sysref_gen u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
    .i_ext_sync_input(i_ext_sync_input), .i_sysref_gen_mode(i_sysref_gen_mode),
    .i_sysref_trigger_option(i_sysref_trigger_option),
    .i_sysref_pulse_count(i_sysref_pulse_count), .i_sysref_wait_count(i_sysref_wait_count),
    .i_sysref_half_period(i_sysref_half_period), .i_start_arm(i_start_arm),
    .i_bias_type(i_bias_type), .i_idle_bias_select(i_idle_bias_select),
    .i_chan_is_sysref(i_chan_is_sysref), .i_chan_delay(i_chan_delay),
    .o_chan_output(o_chan_output), .o_channel_output_comp(o_channel_output_comp),
    .o_chan_power(o_chan_power), .o_crosspoint_level(o_crosspoint_level), .o_busy(o_busy));

  spg_rx_model u_rx (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_clr(clr),
    .i_q(o_chan_output[0]), .i_qn(o_channel_output_comp[0]), .i_pwr(o_chan_power[0]),
    .i_xpt(o_crosspoint_level[0]), .o_pulses(pulses), .o_last_high(last_high),
    .o_low_max(low_max), .o_leg_err(leg_err));

  // 125 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Bounded wait on the busy flag; a hang ends the run
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (o_busy !== v && n < 3000) begin
      cyc(1);
      n++;
    end
    if (o_busy !== v) begin
      failures++;
      $display("[ERR] busy wait expected %h seen %h", v, o_busy);
      end_sim();
    end
  endtask

  task automatic arm();
    i_start_arm = 1'b1;
    cyc(2);
    i_start_arm = 1'b0;
  endtask

  task automatic clear_rx();
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
  endtask

  task automatic stop_gen();
    i_sysref_gen_mode = spg_pkg::GM_TERM;
    wait_busy(1'b0);
    cyc(12);
  endtask

  initial begin
    {i_ext_sync_input, i_start_arm, i_bias_type, i_idle_bias_select, clr} = '0;
    i_ce = 1'b1;
    i_arst_n = 1'b0;
    failures = 0;
    compares = 0;
    i_sysref_gen_mode = spg_pkg::GM_TERM;
    i_sysref_trigger_option = spg_pkg::TO_00;
    i_sysref_pulse_count = 8'h03;
    i_sysref_wait_count = 8'h01;
    i_sysref_half_period = 8'h02;
    i_chan_is_sysref = 8'h0f;
    // Sysref lanes lead the clock lanes, all set before any generation
    for (int c = 0; c < 8; c++) i_chan_delay[6*c +: 6] = (c >= 4) ? 6'h03 : 6'h00;
    cyc(20);
    i_arst_n = 1'b1;
    cyc(3);
    chk("rest q", 16'h0000, {15'h0, o_chan_output[0]});
    chk("rest comp", 16'h0001, {15'h0, o_channel_output_comp[0]});
    chk("rest power", 16'h0000, {15'h0, o_chan_power[0]});
    chk("clk power", 16'h0001, {15'h0, o_chan_power[4]});
    cyc(8);
    k = {31'h0, o_chan_output[4]};
    cyc(1);
    chk("clk toggle", 16'h0001, {15'h0, o_chan_output[4] ^ k[0]});
    // Clock enable low must hold every flop, clock lanes included
    i_ce = 1'b0;
    k = {31'h0, o_chan_output[4]};
    cyc(3);
    chk("ce freeze", {15'h0, k[0]}, {15'h0, o_chan_output[4]});
    i_ce = 1'b1;
    $display("test reset done");
    // Internal single bursts at both ends of the count range
    for (int i = 0; i < 3; i++) begin
      i_sysref_pulse_count = (i == 0) ? 8'h01 : ((i == 1) ? 8'h05 : 8'hff);
      i_sysref_gen_mode = spg_pkg::GM_INT;
      clear_rx();
      arm();
      wait_busy(1'b1);
      cyc(2);
      chk("burst power", 16'h0001, {15'h0, o_chan_power[0]});
      wait_busy(1'b0);
      cyc(10);
      chk("burst count", {8'h00, i_sysref_pulse_count}, pulses);
      chk("burst high", 16'h0002, last_high);
      chk("burst off", 16'h0000, {15'h0, o_chan_power[0]});
      chk("burst legs", 16'h0000, {15'h0, leg_err});
      stop_gen();
    end
    $display("test single burst done");
    // Auto-repeat, then terminate in the middle
    i_sysref_pulse_count = 8'h02;
    i_sysref_trigger_option = spg_pkg::TO_01;
    i_sysref_gen_mode = spg_pkg::GM_INT;
    clear_rx();
    arm();
    cyc(60);
    stop_gen();
    chk("repeat bursts", 16'h0001, {15'h0, pulses > 16'h0004});
    chk("repeat gap", 16'h0001, {15'h0, low_max > 16'h0004});
    chk("repeat tail", 16'h0002, last_high);
    $display("test repeat done");
    // Continuous start by every option, stop by terminate
    i_sysref_half_period = 8'h03;
    for (int t = 0; t < 4; t++) begin
      i_sysref_trigger_option = t[1:0];
      i_ext_sync_input = (t == 3);
      i_sysref_gen_mode = spg_pkg::GM_CONT;
      cyc(4);
      clear_rx();
      if (t[0]) i_ext_sync_input = ~i_ext_sync_input;
      else arm();
      cyc(43);
      stop_gen();
      chk("cont run", 16'h0001, {15'h0, pulses > 16'h0004});
      chk("cont tail", 16'h0003, last_high);
    end
    $display("test continuous done");
    // External triggers: counted by either edge, start and stop by edges
    i_sysref_half_period = 8'h02;
    for (int t = 0; t < 4; t++) begin
      i_sysref_trigger_option = t[1:0];
      i_ext_sync_input = t[0];
      i_sysref_gen_mode = spg_pkg::GM_EXT;
      cyc(4);
      clear_rx();
      arm();
      i_ext_sync_input = ~i_ext_sync_input;
      cyc(4);
      if (t[1]) cyc(30);
      i_ext_sync_input = ~i_ext_sync_input;
      wait_busy(1'b0);
      cyc(6);
      if (t[1]) chk("ext run", 16'h0001, {15'h0, pulses > 16'h0002});
      else chk("ext count", 16'h0002, pulses);
      chk("ext tail", 16'h0002, last_high);
      stop_gen();
    end
    $display("test external done");
    // Pass-through latency, plain then retimed
    for (int m = 0; m < 2; m++) begin
      i_ext_sync_input = 1'b0;
      i_sysref_gen_mode = m[2:0];
      cyc(8);
      for (int lvl = 1; lvl >= 0; lvl--) begin
        i_ext_sync_input = lvl[0];
        k = 0;
        while (o_chan_output[0] !== lvl[0] && k < 20) begin
          cyc(1);
          k++;
        end
        // Two sync flops, core tap, output flop; retimed mode adds one
        chk("pass lag", (m == 1) ? 16'h0005 : 16'h0004, k[15:0]);
        cyc(8);
      end
      chk("pass power", 16'h0001, {15'h0, o_chan_power[0]});
    end
    stop_gen();
    $display("test pass done");
    // Crosspoint rest, then static low with idle bias held
    i_bias_type = 1'b1;
    i_sysref_trigger_option = spg_pkg::TO_00;
    cyc(4);
    chk("xpt rest", 16'h0001, {15'h0, o_crosspoint_level[0]});
    i_sysref_gen_mode = spg_pkg::GM_INT;
    clear_rx();
    arm();
    wait_busy(1'b1);
    wait_busy(1'b0);
    cyc(10);
    chk("xpt count", 16'h0002, pulses);
    chk("xpt back", 16'h0001, {15'h0, o_crosspoint_level[0]});
    stop_gen();
    i_bias_type = 1'b0;
    i_idle_bias_select = 1'b1;
    i_sysref_gen_mode = spg_pkg::GM_INT;
    clear_rx();
    arm();
    cyc(30);
    chk("held low", 16'h0000, pulses);
    chk("held q", 16'h0000, {15'h0, o_chan_output[0]});
    stop_gen();
    $display("test bias done");
    end_sim();
  end
endmodule
